// ===== logic/cdco_consts.svh
// offsets, field positions, reset values and widths for the op execution core
`ifndef CDCO_CONSTS_SVH
`define CDCO_CONSTS_SVH

// widths
`define CDCO_DATA_W        8
`define CDCO_FADDR_W       7
`define CDCO_PC_W          15
`define CDCO_PCLH_W        7
`define CDCO_BADDR_W       8
`define CDCO_BDATA_W       32

// register byte offsets
`define CDCO_OFS_WORK      8'h00
`define CDCO_OFS_STATUS    8'h04
`define CDCO_OFS_PCLH      8'h08
`define CDCO_OFS_PC        8'h0c
`define CDCO_OFS_WDOG      8'h10

// status field positions
`define CDCO_ST_Z          2
`define CDCO_ST_PWRDN_N    3
`define CDCO_ST_TMOUT_N    4

// reset values
`define CDCO_RST_WORK      8'h00
`define CDCO_RST_PCLH      7'h00
`define CDCO_RST_PC        15'h0000
`define CDCO_RST_WDOG      8'h00
`define CDCO_RST_Z         1'b0
`define CDCO_RST_FLAG_N    1'b1

// constants used by the ops
`define CDCO_ZERO8         8'h00
`define CDCO_ONE8          8'h01
`define CDCO_ONE_PC        15'h0001
`define CDCO_DEST_FILE     1'b1

`endif

// ===== logic/cdco_pkg.sv
// types shared by the op execution core
package cdco_pkg;

  // operation presented to the core
  typedef enum logic [2:0] {
    op_nop,
    clear_watchdog_op,
    call_via_work_op,
    complement_file_op,
    clear_file_op,
    decrement_file_op,
    clear_work_op,
    decrement_skip_zero_op
  } cdco_op_t;

  // sequencer states
  typedef enum logic {
    st_exec,
    st_call_load
  } cdco_state_t;

endpackage

// ===== logic/cdco_core.sv
// execution core for clear, complement, decrement, skip and call-via-work ops
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "cdco_consts.svh"
`default_nettype none

module cdco_core #(
  parameter int PRE_W = 8  // watchdog prescaler width
) (
  input  wire logic                         i_mclk,
  input  wire logic                         i_rst,
  // op port
  input  wire logic                         i_op_valid,
  input  wire cdco_pkg::cdco_op_t           i_op,
  input  wire logic [`CDCO_FADDR_W-1:0]     i_file_addr,
  input  wire logic                         i_dest,
  input  wire logic [`CDCO_DATA_W-1:0]      i_file_data,
  output logic                              o_ready,
  // data register file write port
  output logic                              o_file_we,
  output logic [`CDCO_FADDR_W-1:0]          o_file_addr,
  output logic [`CDCO_DATA_W-1:0]           o_file_wdata,
  // return stack push port
  output logic                              o_push,
  output logic [`CDCO_PC_W-1:0]             o_push_addr,
  // program flow
  output logic [`CDCO_PC_W-1:0]             o_pc,
  output logic                              o_skip,
  output logic                              o_wdog_clear,
  // register port
  input  wire logic [`CDCO_BADDR_W-1:0]     i_addr,
  input  wire logic [`CDCO_BDATA_W-1:0]     i_wdata,
  input  wire logic                         i_wr,
  input  wire logic                         i_rd,
  output logic [`CDCO_BDATA_W-1:0]          o_rdata
);
  import cdco_pkg::*;

  // elaboration check on the prescaler width
  if (PRE_W < 1 || PRE_W > 24) begin : g_bad_pre
    $error("cdco_core: PRE_W must lie in 1..24");
  end

  // state
  cdco_state_t                 state;
  logic [`CDCO_DATA_W-1:0]     work;
  logic [`CDCO_PCLH_W-1:0]     pc_high_latch;
  logic [`CDCO_PC_W-1:0]       pc;
  logic [`CDCO_PC_W-1:0]       call_target;
  logic [`CDCO_DATA_W-1:0]     watchdog_counter;
  logic [PRE_W-1:0]            wdog_prescaler;
  logic                        zero_flag;
  logic                        timeout_flag_n;
  logic                        powerdown_flag_n;
  logic                        skip_pend;

  // decode results
  logic                        take;
  logic                        live;
  cdco_op_t                    eff_op;
  logic [`CDCO_DATA_W-1:0]     next_result;
  logic                        next_work_we;
  logic                        next_file_we;
  logic                        next_z_we;
  logic                        next_z;
  logic                        next_skip;
  logic                        wdog_clr;
  logic                        call_start;
  logic                        pre_wrap;
  logic                        bus_wr_work;
  logic                        bus_wr_status;
  logic                        bus_wr_pclh;

  // true when the op stores its result according to the destination bit
  function automatic logic cdco_routes_by_dest(input cdco_op_t op);
    return (op == complement_file_op) || (op == decrement_file_op)
        || (op == decrement_skip_zero_op);
  endfunction

  // register offset match for a write strobe
  function automatic logic cdco_hit(input logic [`CDCO_BADDR_W-1:0] a,
                                    input logic [`CDCO_BADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  // an op is taken only while the sequencer is free
  assign take = i_op_valid && o_ready;
  // a pending skip turns the taken op into a no-operation
  assign live = take && !skip_pend;
  assign eff_op = live ? i_op : op_nop;

  assign wdog_clr   = (eff_op == clear_watchdog_op);
  assign call_start = (eff_op == call_via_work_op);
  assign pre_wrap   = &wdog_prescaler;

  assign bus_wr_work   = i_wr && cdco_hit(i_addr, `CDCO_OFS_WORK);
  assign bus_wr_status = i_wr && cdco_hit(i_addr, `CDCO_OFS_STATUS);
  assign bus_wr_pclh   = i_wr && cdco_hit(i_addr, `CDCO_OFS_PCLH);

  // result, destination and zero flag for the data ops
  always_comb begin
    next_result  = `CDCO_ZERO8;
    next_work_we = 1'b0;
    next_file_we = 1'b0;
    next_z_we    = 1'b0;
    next_z       = 1'b0;
    next_skip    = 1'b0;
    case (eff_op)
      complement_file_op: begin
        next_result = ~i_file_data;
        next_z_we   = 1'b1;
        next_z      = (next_result == `CDCO_ZERO8);
      end
      clear_file_op: begin
        next_result  = `CDCO_ZERO8;
        next_file_we = 1'b1;
        next_z_we    = 1'b1;
        next_z       = 1'b1;
      end
      decrement_file_op: begin
        next_result = i_file_data - `CDCO_ONE8;
        next_z_we   = 1'b1;
        next_z      = (next_result == `CDCO_ZERO8);
      end
      clear_work_op: begin
        next_result  = `CDCO_ZERO8;
        next_work_we = 1'b1;
        next_z_we    = 1'b1;
        next_z       = 1'b1;
      end
      decrement_skip_zero_op: begin
        next_result = i_file_data - `CDCO_ONE8;
        next_skip   = (next_result == `CDCO_ZERO8);
      end
      default: begin
        next_result = `CDCO_ZERO8;
      end
    endcase
    if (cdco_routes_by_dest(eff_op)) begin
      next_file_we = (i_dest == `CDCO_DEST_FILE);
      next_work_we = (i_dest != `CDCO_DEST_FILE);
    end
  end

  // sequencer: call holds the core for a second cycle
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state   <= st_exec;
      o_ready <= 1'b1;
    end else begin
      case (state)
        st_exec: begin
          if (call_start) begin
            state   <= st_call_load;
            o_ready <= 1'b0;
          end
        end
        st_call_load: begin
          state   <= st_exec;
          o_ready <= 1'b1;
        end
        default: begin
          state   <= st_exec;
          o_ready <= 1'b1;
        end
      endcase
    end
  end

  // program counter, push and call target
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pc          <= `CDCO_RST_PC;
      call_target <= `CDCO_RST_PC;
      o_push      <= 1'b0;
      o_push_addr <= `CDCO_RST_PC;
    end else begin
      o_push <= 1'b0;
      if (state == st_call_load) begin
        pc <= call_target;
      end else if (take) begin
        pc <= pc + `CDCO_ONE_PC;
      end
      if (call_start) begin
        o_push      <= 1'b1;
        o_push_addr <= pc + `CDCO_ONE_PC;
        call_target <= {pc_high_latch, work};
      end
    end
  end

  // pc mirror on the output
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_pc <= `CDCO_RST_PC;
    end else if (state == st_call_load) begin
      o_pc <= call_target;
    end else if (take) begin
      o_pc <= pc + `CDCO_ONE_PC;
    end
  end

  // skip pending: armed by a zero skip result, used up by the next op
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      skip_pend <= 1'b0;
      o_skip    <= 1'b0;
    end else if (take) begin
      skip_pend <= next_skip;
      o_skip    <= next_skip;
    end
  end

  // file register write port
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_file_we    <= 1'b0;
      o_file_addr  <= '0;
      o_file_wdata <= `CDCO_ZERO8;
    end else begin
      o_file_we <= next_file_we;
      if (next_file_we) begin
        o_file_addr  <= i_file_addr;
        o_file_wdata <= next_result;
      end
    end
  end

  // work register: an op write wins over a register port write
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      work <= `CDCO_RST_WORK;
    end else if (next_work_we) begin
      work <= next_result;
    end else if (bus_wr_work) begin
      work <= i_wdata[`CDCO_DATA_W-1:0];
    end
  end

  // pc high latch, written by software only
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pc_high_latch <= `CDCO_RST_PCLH;
    end else if (bus_wr_pclh) begin
      pc_high_latch <= i_wdata[`CDCO_PCLH_W-1:0];
    end
  end

  // zero flag: op update wins over software
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      zero_flag <= `CDCO_RST_Z;
    end else if (next_z_we) begin
      zero_flag <= next_z;
    end else if (bus_wr_status) begin
      zero_flag <= i_wdata[`CDCO_ST_Z];
    end
  end

  // power-down flag: set by clear watchdog, else software may write
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      powerdown_flag_n <= `CDCO_RST_FLAG_N;
    end else if (wdog_clr) begin
      powerdown_flag_n <= 1'b1;
    end else if (bus_wr_status) begin
      powerdown_flag_n <= i_wdata[`CDCO_ST_PWRDN_N];
    end
  end

  // time-out flag: clear watchdog sets it, a counter overflow clears it
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      timeout_flag_n <= `CDCO_RST_FLAG_N;
    end else if (wdog_clr) begin
      timeout_flag_n <= 1'b1;
    end else if (pre_wrap && (&watchdog_counter)) begin
      timeout_flag_n <= 1'b0;
    end else if (bus_wr_status) begin
      timeout_flag_n <= i_wdata[`CDCO_ST_TMOUT_N];
    end
  end

  // watchdog prescaler and counter
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      wdog_prescaler   <= '0;
      watchdog_counter <= `CDCO_RST_WDOG;
    end else if (wdog_clr) begin
      wdog_prescaler   <= '0;
      watchdog_counter <= `CDCO_ZERO8;
    end else begin
      wdog_prescaler <= wdog_prescaler + 1'b1;
      if (pre_wrap) begin
        watchdog_counter <= watchdog_counter + `CDCO_ONE8;
      end
    end
  end

  // clear pulse toward the outside watchdog
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_wdog_clear <= 1'b0;
    end else begin
      o_wdog_clear <= wdog_clr;
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      o_rdata <= '0;
      case (i_addr)
        `CDCO_OFS_WORK:   o_rdata[`CDCO_DATA_W-1:0] <= work;
        `CDCO_OFS_STATUS: begin
          o_rdata[`CDCO_ST_Z]    <= zero_flag;
          o_rdata[`CDCO_ST_PWRDN_N] <= powerdown_flag_n;
          o_rdata[`CDCO_ST_TMOUT_N] <= timeout_flag_n;
        end
        `CDCO_OFS_PCLH:   o_rdata[`CDCO_PCLH_W-1:0] <= pc_high_latch;
        `CDCO_OFS_PC:     o_rdata[`CDCO_PC_W-1:0] <= pc;
        `CDCO_OFS_WDOG:   o_rdata[`CDCO_DATA_W-1:0] <= watchdog_counter;
        default:          o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

endmodule // cdco_core

`default_nettype wire

// ===== sim/cdco_core_assertions.sv
// concurrent checks on the op execution core ports
`timescale 1ns/1ps
`include "cdco_consts.svh"
`default_nettype none
module cdco_core_assertions #(
  parameter int PRE_W = 8  // watchdog prescaler width
) (
  input  wire logic               i_mclk,
  input  wire logic               i_rst,
  input  wire logic               i_op_valid,
  input  wire cdco_pkg::cdco_op_t i_op,
  input  wire logic               i_dest,
  input  wire logic [7:0]         i_file_data,
  input  wire logic               o_ready,
  input  wire logic               o_file_we,
  input  wire logic [7:0]         o_file_wdata,
  input  wire logic               o_push,
  input  wire logic [14:0]        o_push_addr,
  input  wire logic [14:0]        o_pc,
  input  wire logic               o_skip,
  input  wire logic               o_wdog_clear
);
  import cdco_pkg::*;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // op taken and not discarded
  logic tk;
  assign tk = i_op_valid && o_ready && !o_skip;
  a_wdog_clear_pulse: assert property (tk && i_op == clear_watchdog_op |=> o_wdog_clear)
    else $error("watchdog clear pulse missing");
  a_call_push: assert property (tk && i_op == call_via_work_op |=>
    o_push && !o_ready && o_push_addr == $past(o_pc) + `CDCO_ONE_PC)
    else $error("call push wrong");
  a_call_two_cyc: assert property (o_push |=> o_ready && !o_push)
    else $error("call not two cycles");
  a_complement_value: assert property (tk && i_op == complement_file_op && i_dest |=>
    o_file_we && o_file_wdata == ~$past(i_file_data)) else $error("complement wrong");
  a_clear_file_zero: assert property (tk && i_op == clear_file_op |=>
    o_file_we && o_file_wdata == `CDCO_ZERO8) else $error("clear file wrong");
  a_dec_value: assert property (tk && i_dest && (i_op == decrement_file_op ||
    i_op == decrement_skip_zero_op) |=> o_file_we && o_file_wdata == $past(i_file_data) - 8'h01)
    else $error("decrement wrong");
  a_work_no_write: assert property (tk && !i_dest && i_op inside {complement_file_op,
    decrement_file_op, decrement_skip_zero_op, clear_work_op} |=> !o_file_we)
    else $error("file written for work destination");
  a_skip_set: assert property (tk && i_op == decrement_skip_zero_op |=>
    o_skip == ($past(i_file_data) == `CDCO_ONE8)) else $error("skip flag wrong");
  a_skip_discard: assert property (i_op_valid && o_ready && o_skip |=>
    !o_file_we && !o_push && !o_wdog_clear && !o_skip) else $error("skipped op had effect");
  a_pc_step: assert property (i_op_valid && o_ready && i_op != op_nop &&
    (o_skip || i_op != call_via_work_op) |=> o_pc == $past(o_pc) + `CDCO_ONE_PC)
    else $error("pc step wrong");
  c_call: cover property (o_push);
  c_skip: cover property (o_skip && i_op_valid);
  c_wdog: cover property (o_wdog_clear);
endmodule // cdco_core_assertions
bind cdco_core cdco_core_assertions #(.PRE_W(PRE_W)) u_chk (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_op_valid(i_op_valid), .i_op(i_op), .i_dest(i_dest),
  .i_file_data(i_file_data), .o_ready(o_ready), .o_file_we(o_file_we),
  .o_file_wdata(o_file_wdata), .o_push(o_push), .o_push_addr(o_push_addr), .o_pc(o_pc),
  .o_skip(o_skip), .o_wdog_clear(o_wdog_clear));
`default_nettype wire

// ===== sim/cdco_mem_model.sv
// data register file and return stack top seen by the core
`timescale 1ns/1ps
`default_nettype none
module cdco_mem_model (
  input  wire logic        i_mclk,
  input  wire logic        i_file_we,
  input  wire logic [6:0]  i_wr_addr,
  input  wire logic [7:0]  i_wr_data,
  input  wire logic [6:0]  i_rd_addr,
  input  wire logic        i_push,
  input  wire logic [14:0] i_push_addr,
  output logic [7:0]       o_rd_data
);
  logic [7:0]  mem [128];
  logic [14:0] top;
  // asynchronous read of the addressed register
  assign o_rd_data = mem[i_rd_addr];
  // file writes and stack pushes
  always @(posedge i_mclk) begin
    if (i_file_we) mem[i_wr_addr] <= i_wr_data;
    if (i_push) top <= i_push_addr;
  end
  initial begin
    top = 15'h0000;
    foreach (mem[i]) mem[i] = 8'(i * 3);
  end
endmodule // cdco_mem_model
`default_nettype wire

// ===== sim/test_core_clear_decrement_call_ops.sv
// self-checking bench for the op execution core
`timescale 1ns/1ps
`include "cdco_consts.svh"
`default_nettype none
module test_core_clear_decrement_call_ops;
  import cdco_pkg::*;
  logic        i_mclk, i_rst, i_op_valid, i_dest, i_wr, i_rd, o_ready, o_file_we;
  logic        o_push, o_skip, o_wdog_clear, z, skp;
  cdco_op_t    i_op;
  logic [6:0]  i_file_addr, o_file_addr, h;
  logic [7:0]  i_file_data, o_file_wdata, i_addr, w;
  logic [14:0] o_push_addr, o_pc, pc;
  logic [31:0] i_wdata, o_rdata;
  int          num_errors, comparisons;
  logic [7:0]  corner [3] = '{8'h00, 8'h01, 8'hff};

  cdco_core #(.PRE_W(2)) u_dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_op_valid(i_op_valid), .i_op(i_op),
    .i_file_addr(i_file_addr), .i_dest(i_dest), .i_file_data(i_file_data), .o_ready(o_ready),
    .o_file_we(o_file_we), .o_file_addr(o_file_addr), .o_file_wdata(o_file_wdata),
    .o_push(o_push), .o_push_addr(o_push_addr), .o_pc(o_pc), .o_skip(o_skip),
    .o_wdog_clear(o_wdog_clear), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata));
  cdco_mem_model u_mem (
    .i_mclk(i_mclk), .i_file_we(o_file_we), .i_wr_addr(o_file_addr), .i_wr_data(o_file_wdata),
    .i_rd_addr(i_file_addr), .i_push(o_push), .i_push_addr(o_push_addr),
    .o_rd_data(i_file_data));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    i_addr <= a; i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata & m, e);
  endtask
  // offer one op with a chosen register value and check its effects
  task automatic do_op(input cdco_op_t op, input logic [6:0] a, input logic d,
                       input logic [7:0] v);
    logic [7:0] r;
    logic we, nskp, tw;
    r = (op == complement_file_op) ? ~v :
        (op inside {clear_file_op, clear_work_op}) ? 8'h00 : v - 8'h01;
    tw = op inside {complement_file_op, decrement_file_op, decrement_skip_zero_op};
    we = !skp && (op == clear_file_op || (tw && d));
    nskp = !skp && op == decrement_skip_zero_op && r == 8'h00;
    u_mem.mem[a] = v;
    i_op <= op; i_file_addr <= a; i_dest <= d; i_op_valid <= 1'b1;
    @(posedge i_mclk); #1;
    chk({o_file_we, o_wdog_clear}, {we, !skp && op == clear_watchdog_op});
    if (we) chk({o_file_addr, o_file_wdata}, {a, r});
    chk(o_skip, nskp);
    if (!skp && op == call_via_work_op) begin
      chk({o_push, o_push_addr}, {1'b1, pc + 15'h1});
      chk({o_pc, o_ready}, {pc + 15'h1, 1'b0});
      i_op_valid <= 1'b0;
      @(posedge i_mclk); #1;
      chk({o_pc, o_ready, u_mem.top}, {h, w, 1'b1, pc + 15'h1});
      pc = {h, w};
    end else begin
      pc = pc + 15'h1;
      chk({o_push, o_pc}, {1'b0, pc});
    end
    if (!skp && tw && !d) w = r;
    if (!skp && op == clear_work_op) w = 8'h00;
    if (!skp && op inside {complement_file_op, decrement_file_op, clear_file_op, clear_work_op})
      z = (r == 8'h00);
    skp = nskp;
  endtask
  // op, a discarded follower when skipping, then work and zero flag readback
  task automatic run(input cdco_op_t op, input logic [6:0] a, input logic d, input logic [7:0] v);
    do_op(op, a, d, v);
    if (skp) do_op(cdco_op_t'($urandom_range(1, 7)), 7'($urandom), 1'($urandom), 8'($urandom));
    i_op_valid <= 1'b0;
    reg_rd(`CDCO_OFS_WORK, 32'hffffffff, {24'h0, w});
    reg_rd(`CDCO_OFS_STATUS, 32'h4, {29'h0, z, 2'h0});
  endtask

  // clock generator
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  // bound on the whole run
  initial begin
    repeat (20000) @(posedge i_mclk);
    num_errors++;
    report_and_stop();
  end
  // main sequence
  initial begin
    i_rst = 1'b1; i_op_valid = 1'b0; i_op = op_nop; i_file_addr = 7'h00; i_dest = 1'b0;
    i_addr = 8'h00; i_wdata = 32'h0; i_wr = 1'b0; i_rd = 1'b0;
    num_errors = 0; comparisons = 0; w = 8'h00; z = 1'b0; pc = 15'h0; h = 7'h00; skp = 1'b0;
    void'($urandom(32'h93d01c6a));
    repeat (10) @(posedge i_mclk);
    #1 i_rst <= 1'b0;
    reg_rd(`CDCO_OFS_STATUS, 32'h1c, 32'h18);
    // corner values for the complement and decrement ops and both destinations, then one clear_file_op and one clear_work_op
    for (int k = 0; k < 3; k++) begin
      for (int d = 0; d < 2; d++) begin
        run(complement_file_op, 7'h10, 1'(d), corner[k]);
        run(decrement_file_op, 7'h11, 1'(d), corner[k]);
        run(decrement_skip_zero_op, 7'h12, 1'(d), corner[k]);
      end
    end
    run(clear_file_op, 7'h7f, 1'b0, 8'h5a);
    run(clear_work_op, 7'h00, 1'b0, 8'h33);
    // random ops with occasional software writes to work and the pc latch
    repeat (60) begin
      if ($urandom_range(0, 3) == 0) begin
        w = 8'($urandom);
        h = 7'($urandom);
        reg_wr(`CDCO_OFS_WORK, {24'h0, w});
        reg_wr(`CDCO_OFS_PCLH, {25'h0, h});
      end
      run(cdco_op_t'($urandom_range(1, 7)), 7'($urandom), 1'($urandom),
          ($urandom_range(0, 1) == 1) ? corner[$urandom_range(0, 2)] : 8'($urandom));
    end
    // watchdog clear restores both flags and restarts the counter
    reg_wr(`CDCO_OFS_STATUS, 32'h0);
    z = 1'b0;
    do_op(clear_watchdog_op, 7'h00, 1'b0, 8'h00);
    i_op_valid <= 1'b0;
    @(posedge i_mclk); #1;
    reg_rd(`CDCO_OFS_WDOG, 32'hff, 32'h0);
    repeat (3) @(posedge i_mclk);
    #1 reg_rd(`CDCO_OFS_WDOG, 32'hff, 32'h1);
    reg_rd(`CDCO_OFS_STATUS, 32'h1c, 32'h18);
    reg_rd(`CDCO_OFS_PC, 32'hffffffff, {17'h0, pc});
    reg_rd(8'h14, 32'hffffffff, 32'h0);
    report_and_stop();
  end
endmodule // test_core_clear_decrement_call_ops
`default_nettype wire
